// ===== rtl/ierw_host.sv
// Master end of the two-wire EEPROM engine: makes the link clock by a
// divider, runs page writes and random or sequential reads, and polls.
// Assumes the device end of ierw_if on the same link.
`timescale 1ns/1ps
`default_nettype none
module ierw_host #(
  parameter int unsigned QTR = ierw_pkg::LINK_QTR,
  parameter int unsigned LEN_W = ierw_pkg::LEN_W
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  ierw_if.host bus,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic [ierw_pkg::AW-1:0] i_cmd_addr,
  input wire logic [ierw_pkg::CS_W-1:0] i_cmd_cs,
  input wire logic [LEN_W-1:0] i_cmd_len,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic o_done,
  output logic o_refused
);
  import ierw_pkg::*;

  localparam int unsigned QW = $clog2(QTR);

  // The device needs a few clocks to see an edge and answer
  if (QTR < 4 || LEN_W < 1) begin : g_bad_param
    $error("QTR below 4 or LEN_W below 1");
  end

  typedef struct packed {
    ierw_hph_e ph;
    ierw_step_e step;
    logic [1:0] q;
    logic [QW-1:0] qc;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic scl_lo;
    logic sda_lo;
    logic [1:0] sda_q;
    logic rd;
    logic [AW-1:0] addr;
    logic [CS_W-1:0] cs;
    logic [LEN_W-1:0] len;
    logic again;
    logic refd;
    logic done;
    logic refused;
    logic [1:0][7:0] fq;
    logic [1:0] fcnt;
  } ierw_host_s;

  ierw_host_s r;
  ierw_host_s n;
  logic at_end;
  logic nacked;
  logic want_wr;
  logic want_sp;
  logic stall;
  logic last;

  // ==========================================================
  // Byte boundary decisions
  // ==========================================================
  assign last = (r.len == LEN_W'(1));
  assign nacked = (r.ph == H_TX) && r.sda_q[1];
  assign at_end = (r.ph == H_TX || r.ph == H_RX) && r.q == 2'h3 &&
                  r.qc == QW'(QTR - 1) && r.bcnt == 4'h8;
  assign want_wr = !nacked && r.ph == H_TX &&
                   ((r.step == ST_BADDR && !r.rd) || (r.step == ST_WDATA && !last));
  assign want_sp = (!nacked && r.ph == H_TX && r.step == ST_DEVR) ||
                   (r.ph == H_RX && !last);
  // Back-pressure holds the clock high at a byte boundary
  assign stall = at_end && ((want_wr && !i_wr_valid) || (want_sp && r.fcnt == 2'h2));
  assign o_wr_ready = at_end && want_wr;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin : p_next
    logic push;
    logic b;
    logic [7:0] pd;
    push = 1'h0;
    b = 1'h1;
    pd = {r.sh[6:0], r.sda_q[1]};
    n = r;
    n.sda_q = {r.sda_q[0], bus.sda};
    n.done = 1'h0;
    n.refused = 1'h0;
    if (r.ph == H_IDLE) begin
      if (i_cmd_valid) begin
        n.ph = H_START;
        n.step = ST_DEVW;
        n.q = '0;
        n.qc = '0;
        n.rd = i_cmd_read;
        n.addr = i_cmd_addr;
        n.cs = i_cmd_cs;
        n.len = (i_cmd_len == '0) ? LEN_W'(1) : i_cmd_len;
        n.again = 1'h0;
        n.refd = 1'h0;
      end
    end else if (stall) begin
      n.qc = r.qc;
    end else if (r.qc != QW'(QTR - 1)) begin
      n.qc = r.qc + 1'h1;
    end else if (r.q != 2'h3) begin
      n.qc = '0;
      n.q = r.q + 2'h1;
    end else begin
      n.qc = '0;
      n.q = '0;
      case (r.ph)
        H_START: begin
          // direction bit one only for the read address
          n.ph = H_TX;
          n.bcnt = '0;
          n.sh = {DEV_TYPE, r.cs, r.addr[AW-1], r.step == ST_DEVR};
        end
        H_STOP: begin
          if (r.again) begin
            n.ph = H_START;
            n.step = ST_DEVW;
            n.again = 1'h0;
          end else begin
            n.ph = H_IDLE;
            n.done = 1'h1;
            n.refused = r.refd;
          end
        end
        default: begin
          if (r.bcnt != 4'h8) begin
            n.bcnt = r.bcnt + 4'h1;
            n.sh = pd;
            push = (r.ph == H_RX) && r.bcnt == 4'h7;
          end else begin
            n.bcnt = '0;
            if (nacked) begin
              // unanswered write slave address means still busy, so retry
              n.ph = H_STOP;
              n.again = (r.step == ST_DEVW);
              n.refd = (r.step != ST_DEVW);
            end else begin
              case (r.step)
                // byte address follows the slave address
                ST_DEVW: begin
                  n.step = ST_BADDR;
                  n.sh = r.addr[7:0];
                end
                ST_BADDR: begin
                  if (r.rd) begin
                    n.ph = H_START;
                    n.step = ST_DEVR;
                  end else begin
                    n.step = ST_WDATA;
                    n.sh = i_wr_data;
                  end
                end
                ST_WDATA: begin
                  // further bytes until the count runs out
                  if (last) begin
                    n.ph = H_STOP;
                  end else begin
                    n.len = r.len - 1'h1;
                    n.sh = i_wr_data;
                  end
                end
                ST_DEVR: begin
                  n.ph = H_RX;
                  n.step = ST_RDATA;
                end
                default: begin
                  // last byte was answered with nack
                  if (last) begin
                    n.ph = H_STOP;
                  end else begin
                    n.len = r.len - 1'h1;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
    // Pin levels registered from the next state, so the clock never glitches
    if (n.ph == H_TX && n.bcnt != 4'h8) begin
      b = n.sh[7];
    end
    if (n.ph == H_RX && n.bcnt == 4'h8) begin
      b = (n.len == LEN_W'(1));
    end
    case (n.ph)
      H_START: begin
        n.scl_lo = !(n.q == 2'h1 || n.q == 2'h2);
        n.sda_lo = n.q[1];
      end
      H_STOP: begin
        n.scl_lo = (n.q == 2'h0);
        n.sda_lo = !n.q[1];
      end
      H_TX, H_RX: begin
        n.scl_lo = !n.q[1];
        n.sda_lo = !b;
      end
      default: begin
        n.scl_lo = 1'h0;
        n.sda_lo = 1'h0;
      end
    endcase
    // Two-entry read buffer
    if (r.fcnt != 2'h0 && i_rd_ready) begin
      n.fq[0] = r.fq[1];
      n.fcnt = r.fcnt - 2'h1;
    end
    if (push) begin
      n.fq[n.fcnt[0]] = pd;
      n.fcnt = n.fcnt + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.scl = ~r.scl_lo;
  assign bus.host_sda_o = 1'h0;
  assign bus.host_sda_oe_n = ~r.sda_lo;
  assign o_cmd_ready = (r.ph == H_IDLE);
  assign o_rd_valid = (r.fcnt != 2'h0);
  assign o_rd_data = r.fq[0];
  assign o_done = r.done;
  assign o_refused = r.refused;
endmodule : ierw_host
`default_nettype wire

// ===== rtl/ierw_pkg.sv
// Shared constants and types of the two-wire EEPROM read/write engine.
// Assumes both ends run on one 100 MHz system clock.
// Behaviour
// - Write sends 8-bit byte address after slave
// - Device acknowledges byte address and permitted data
// - Stop after data starts locked-out program cycle
// - Pages are sixteen aligned consecutive bytes
// - Write address wraps inside its page
// - Page write may start at any offset
// - Up to fifteen more bytes, each acknowledged
// - Over sixteen bytes overwrite earlier latched data
// - Polling address unacknowledged until programming ends
// - Protect high refuses upper-half data, no program
// - Read starts with direction bit one
// - Counter holds last accessed address plus one
// - Current read sends one byte, ends on nack
// - Random read: dummy write, repeated start, read
// - Master ack requests next byte, nack ends
// - Read counter spans whole array, wraps to zero
// - Lowest select bit picks block, others match pins
// - Device releases data line, waits stop on nack
`default_nettype none
package ierw_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_TIME_US = 5000;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  // Device type code: the value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'hC;
  localparam int unsigned AW = 9;
  localparam int unsigned MEM_BYTES = 512;
  localparam int unsigned PAGE_BITS = 4;
  localparam int unsigned CS_W = 2;
  localparam int unsigned SA_RW = 0;
  localparam int unsigned SA_BLK = 1;
  localparam int unsigned SA_CS = 2;
  localparam logic RW_READ = 1'h1;
  // Quarter of the link clock period, in system clocks
  localparam int unsigned LINK_QTR = 5;
  localparam int unsigned LEN_W = 5;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_DADDR = 3'h1, D_WADDR = 3'h3, D_WDATA = 3'h2,
    D_RDATA = 3'h6, D_RACK = 3'h7, D_WSTOP = 3'h5
  } ierw_dst_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_TX = 3'h3, H_RX = 3'h2, H_STOP = 3'h6
  } ierw_hph_e;

  typedef enum logic [2:0] {
    ST_DEVW = 3'h0, ST_BADDR = 3'h1, ST_WDATA = 3'h3, ST_DEVR = 3'h2, ST_RDATA = 3'h6
  } ierw_step_e;
endpackage : ierw_pkg
`default_nettype wire

// ===== rtl/ierw_if.sv
// Two-wire link between the EEPROM device end and the bus master end.
// Assumes both drivers are open drain: a released line reads high.
`timescale 1ns/1ps
`default_nettype none
interface ierw_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Wired AND stands in for the pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
endinterface : ierw_if
`default_nettype wire

// ===== rtl/ierw_dev.sv
// Device end of the two-wire EEPROM engine: 512-byte array, page writes,
// reads, and a timed program cycle that locks the link out.
// Assumes each link clock phase lasts at least five system clocks.
`timescale 1ns/1ps
`default_nettype none
module ierw_dev #(
  parameter int unsigned PROG_CYCLES = ierw_pkg::PROG_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  ierw_if.dev bus,
  input wire logic [ierw_pkg::CS_W-1:0] i_chip_select_pins,
  input wire logic i_write_protect,
  output logic o_busy
);
  import ierw_pkg::*;

  localparam int unsigned CW = $clog2(PROG_CYCLES);

  // Committing a page takes one clock per byte inside the lockout
  if (PROG_CYCLES <= 2 ** PAGE_BITS) begin : g_bad_prog
    $error("PROG_CYCLES too short to commit a page");
  end

  typedef struct packed {
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] wp_q;
    logic [1:0][CS_W-1:0] cs_q;
    ierw_dst_e st;
    logic [3:0] cnt;
    logic ack;
    logic rw;
    logic blk;
    logic [7:0] sh;
    logic [AW-1:0] addr;
    logic [15:0][7:0] pbuf;
    logic [15:0] pmask;
    logic [AW-PAGE_BITS-1:0] pbase;
    logic drv;
    logic busy;
    logic [CW-1:0] pcnt;
    logic [4:0] cidx;
  } ierw_dev_s;

  ierw_dev_s r;
  ierw_dev_s n;
  // Link samplers reset to the idle high level, so no false edge follows reset
  localparam ierw_dev_s DEV_RST = ierw_dev_s'({6'h3F, {($bits(ierw_dev_s) - 6){1'h0}}});
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rdata;
  logic we;
  logic ok;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // ==========================================================
  // Link edge and condition detection
  // ==========================================================
  assign scl_rise = r.scl_q[1] & ~r.scl_q[2];
  assign scl_fall = ~r.scl_q[1] & r.scl_q[2];
  assign start_c = r.scl_q[1] & r.scl_q[2] & ~r.sda_q[1] & r.sda_q[2];
  assign stop_c = r.scl_q[1] & r.scl_q[2] & r.sda_q[1] & ~r.sda_q[2];
  assign rdata = mem[r.addr];

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    n = r;
    we = 1'h0;
    ok = 1'h0;
    n.scl_q = {r.scl_q[1:0], bus.scl};
    n.sda_q = {r.sda_q[1:0], bus.sda};
    n.wp_q = {r.wp_q[0], i_write_protect};
    n.cs_q = {r.cs_q[0], i_chip_select_pins};
    if (r.busy) begin
      // no acknowledge until the count ends
      n.st = D_IDLE;
      n.drv = 1'h0;
      if (r.cidx != 5'h10) begin
        we = r.pmask[r.cidx[3:0]];
        n.cidx = r.cidx + 5'h1;
      end
      if (r.pcnt == '0) begin
        n.busy = 1'h0;
        n.pmask = '0;
      end else begin
        n.pcnt = r.pcnt - 1'h1;
      end
    end else if (stop_c) begin
      n.st = D_IDLE;
      n.drv = 1'h0;
      // stop with latched data starts programming
      // refused data leaves nothing to program
      if (r.pmask != '0) begin
        n.busy = 1'h1;
        n.pcnt = CW'(PROG_CYCLES - 1);
        n.cidx = '0;
        n.pbase = r.addr[AW-1:PAGE_BITS];
      end
    end else if (start_c) begin
      // A repeated start drops unfinished write data
      n.st = D_DADDR;
      n.cnt = '0;
      n.ack = 1'h0;
      n.drv = 1'h0;
      n.pmask = '0;
    end else begin
      case (r.st)
        D_DADDR, D_WADDR, D_WDATA: begin
          if (!r.ack) begin
            if (scl_rise) begin
              n.sh = {r.sh[6:0], r.sda_q[1]};
              n.cnt = r.cnt + 4'h1;
            end else if (scl_fall && r.cnt == 4'h8) begin
              n.cnt = '0;
              case (r.st)
                // type and select pins must match
                D_DADDR: ok = (r.sh[7:4] == DEV_TYPE) &&
                              (r.sh[SA_CS +: CS_W] == r.cs_q[1]);
                D_WADDR: ok = 1'h1;
                default: ok = !(r.wp_q[1] && r.addr[AW-1]);
              endcase
              if (!ok) begin
                n.st = (r.st == D_DADDR) ? D_IDLE : D_WSTOP;
              end else begin
                n.ack = 1'h1;
                n.drv = 1'h1;
                case (r.st)
                  D_DADDR: begin
                    n.rw = r.sh[SA_RW];
                    n.blk = r.sh[SA_BLK];
                  end
                  D_WADDR: n.addr = {r.blk, r.sh};
                  default: begin
                    n.pbuf[r.addr[PAGE_BITS-1:0]] = r.sh;
                    n.pmask[r.addr[PAGE_BITS-1:0]] = 1'h1;
                    n.addr[PAGE_BITS-1:0] = r.addr[PAGE_BITS-1:0] + 4'h1;
                  end
                endcase
              end
            end
          end else if (scl_fall) begin
            n.ack = 1'h0;
            n.drv = 1'h0;
            if (r.st == D_DADDR && r.rw == RW_READ) begin
              // first read bit follows the address ack
              n.st = D_RDATA;
              n.sh = rdata;
              n.drv = ~rdata[7];
            end else if (r.st == D_DADDR) begin
              n.st = D_WADDR;
            end else begin
              n.st = D_WDATA;
            end
          end
        end
        D_RDATA: begin
          if (scl_fall) begin
            if (r.cnt == 4'h7) begin
              // release the line for the master's ack
              n.drv = 1'h0;
              n.st = D_RACK;
              n.addr = r.addr + 1'h1;
            end else begin
              n.cnt = r.cnt + 4'h1;
              n.sh = {r.sh[6:0], 1'h0};
              n.drv = ~r.sh[6];
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            // ack asks for more, nack ends
            // no ack means wait for stop
            if (r.sda_q[1]) begin
              n.st = D_WSTOP;
            end else begin
              n.ack = 1'h1;
            end
          end else if (scl_fall && r.ack) begin
            n.ack = 1'h0;
            n.cnt = '0;
            n.st = D_RDATA;
            n.sh = rdata;
            n.drv = ~rdata[7];
          end
        end
        D_IDLE, D_WSTOP: n.drv = 1'h0;
        default: begin
          n.st = D_IDLE;
          n.drv = 1'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // State and array
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  // a page is sixteen aligned bytes
  always_ff @(posedge i_clk) begin
    if (we) begin
      mem[{r.pbase, r.cidx[PAGE_BITS-1:0]}] <= r.pbuf[r.cidx[PAGE_BITS-1:0]];
    end
  end

  assign bus.dev_sda_o = 1'h0;
  assign bus.dev_sda_oe_n = ~r.drv;
  assign o_busy = r.busy;
endmodule : ierw_dev
`default_nettype wire

// ===== testbench/ierw_assertions.sv
// Concurrent checks on the two-wire link between both EEPROM engine ends.
// Assumes one system clock domain and open-drain drivers on the data line.
`timescale 1ns/1ps
`default_nettype none
module ierw_assertions #(
  parameter int unsigned PROG_CYCLES = 40
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic o_busy
);
  logic [31:0] busy_cnt_r;
  logic [3:0] stop_age_r;
  logic sda_q_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================================
  // Helper counters
  // Stop age saturates, so a lockout long after any stop is always caught
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_cnt_r <= 32'h0;
      stop_age_r <= 4'hF;
      sda_q_r <= 1'h1;
    end else begin
      busy_cnt_r <= o_busy ? busy_cnt_r + 32'h1 : 32'h0;
      sda_q_r <= sda;
      if (scl && sda && !sda_q_r) begin
        stop_age_r <= 4'h0;
      end else if (stop_age_r != 4'hF) begin
        stop_age_r <= stop_age_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Link properties
  a_open_drain_only:
    assert property (host_sda_o == 1'h0 && dev_sda_o == 1'h0)
    else $error("data line driven high by an end");
  a_busy_stays_quiet:
    assert property (o_busy |-> dev_sda_oe_n)
    else $error("device drives the line while programming");
  a_busy_after_stop:
    assert property ($rose(o_busy) |-> stop_age_r < 4'hA)
    else $error("program cycle started without a recent stop");
  a_busy_full_length:
    assert property ($fell(o_busy) |->
      busy_cnt_r <= PROG_CYCLES && busy_cnt_r + 32'h8 >= PROG_CYCLES)
    else $error("program lockout length off");
  a_busy_holds_on:
    assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("program lockout dropped early");
  a_dev_edge_low:
    assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  a_dev_release_bound:
    assert property ($fell(dev_sda_oe_n) |-> ##[1:200] dev_sda_oe_n)
    else $error("device holds data line too long");
  a_no_contention:
    assert property (!dev_sda_oe_n && scl |-> host_sda_oe_n)
    else $error("both ends drive during a clock high phase");

  cover property ($rose(o_busy));
  cover property ($fell(o_busy));
  cover property (!dev_sda_oe_n && scl);
endmodule : ierw_assertions
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench: host end and device end joined on one link.
// Assumes the host polls on its own while the device is programming.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ierw_pkg::*;
  typedef logic [7:0] ierw_tbq_t [$];
  localparam int unsigned PROG = 2000;

  logic i_clk = 1'h0;
  logic i_reset_n;
  logic [1:0] pins;
  logic [1:0] cs;
  logic wp;
  logic cmd_valid, cmd_read, wr_valid, rd_ready;
  logic [8:0] cmd_addr;
  logic [4:0] cmd_len;
  logic [7:0] wr_data;
  logic cmd_ready, wr_ready, rd_valid, done, refused_o, busy;
  logic [7:0] rd_data;
  logic [7:0] mem [512];
  logic [7:0] rdq [$];
  logic fin, refused, ack_seen, busy_take;
  int fail_count = 0;
  int compares = 0;

  always #5 i_clk = ~i_clk;

  ierw_if u_ierw_if ();
  ierw_dev #(.PROG_CYCLES(PROG)) u_ierw_dev (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .bus(u_ierw_if), .i_chip_select_pins(pins), .i_write_protect(wp), .o_busy(busy));
  ierw_host u_ierw_host (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(u_ierw_if),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read),
    .i_cmd_addr(cmd_addr), .i_cmd_cs(cs), .i_cmd_len(cmd_len), .i_wr_data(wr_data),
    .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_done(done), .o_refused(refused_o));
  ierw_assertions #(.PROG_CYCLES(PROG)) u_ierw_assertions (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .scl(u_ierw_if.scl), .sda(u_ierw_if.sda),
    .host_sda_o(u_ierw_if.host_sda_o), .host_sda_oe_n(u_ierw_if.host_sda_oe_n),
    .dev_sda_o(u_ierw_if.dev_sda_o), .dev_sda_oe_n(u_ierw_if.dev_sda_oe_n), .o_busy(busy));

  // ==========================================================================
  // Compare and report
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic complete_run;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Access tasks
  task automatic do_reset;
    @(posedge i_clk);
    i_reset_n <= 1'h0;
    cmd_valid <= 1'h0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'h1;
  endtask : do_reset

  // A hang is expected only when nobody answers, so its bound is short
  task automatic run_cmd(input logic rd, input logic [8:0] a, input logic [4:0] n,
      input ierw_tbq_t wd, input int stall, input bit hang_ok);
    int k;
    int wi;
    wi = 0;
    fin = 1'h0;
    ack_seen = 1'h0;
    rdq.delete();
    @(posedge i_clk);
    cmd_valid <= 1'h1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_len <= n;
    wr_valid <= !rd && (wd.size() > 0);
    if (wd.size() > 0) wr_data <= wd[0];
    // Keep draining the read buffer after the stop: a slow reader still holds bytes
    for (k = 0; k < (hang_ok ? 3000 : 20000) && (!fin || (rd && rdq.size() < int'(n)));
        k++) begin
      @(posedge i_clk);
      if (!u_ierw_if.dev_sda_oe_n) ack_seen = 1'h1;
      if (cmd_valid && cmd_ready) begin
        cmd_valid <= 1'h0;
        busy_take = busy;
      end
      if (wr_valid && wr_ready) begin
        wi++;
        if (wi < wd.size()) wr_data <= wd[wi];
        else wr_valid <= 1'h0;
      end
      if (rd_valid && rd_ready) rdq.push_back(rd_data);
      rd_ready <= (stall == 0) || (k % stall == 0);
      if (done) begin
        fin = 1'h1;
        refused = refused_o;
      end
    end
    @(posedge i_clk);
    rd_ready <= 1'h0;
    wr_valid <= 1'h0;
    if (!fin && !hang_ok) begin
      fail_count++;
      $display("BAD t=%0t timeout got=%h exp=%h", $time, fin, 1'h1);
      complete_run;
    end
  endtask : run_cmd

  task automatic do_write(input logic [8:0] a, input ierw_tbq_t d, input logic exp_ref);
    logic hit;
    int i;
    run_cmd(1'h0, a, 5'(d.size()), d, 0, 1'b0);
    chk1(refused, exp_ref);
    hit = 1'h0;
    for (i = 0; i < 30; i++) begin
      @(posedge i_clk);
      hit |= busy;
    end
    chk1(hit, !exp_ref);
    // In-page wrap: only the low four address bits advance
    if (!exp_ref) for (i = 0; i < d.size(); i++) mem[{a[8:4], 4'(a[3:0] + i)}] = d[i];
  endtask : do_write

  task automatic do_read(input logic [8:0] a, input int n, input int stall);
    int i;
    ierw_tbq_t none;
    run_cmd(1'h1, a, 5'(n), none, stall, 1'b0);
    chk1(refused, 1'h0);
    chk8(8'(rdq.size()), 8'(n));
    for (i = 0; i < rdq.size(); i++) chk8(rdq[i], mem[9'(a + i)]);
  endtask : do_read

  // ==========================================================================
  // Main sequence
  initial begin
    ierw_tbq_t d;
    i_reset_n = 1'h0;
    pins = 2'h2;
    cs = 2'h2;
    wp = 1'h0;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_addr = 9'h000;
    cmd_len = 5'h00;
    wr_data = 8'h00;
    wr_valid = 1'h0;
    rd_ready = 1'h0;
    do_reset;
    // Seventeen bytes from mid-page: the last one overwrites the first slot
    for (int i = 0; i < 17; i++) d.push_back(8'hA0 + 8'(i));
    do_write(9'h11E, d, 1'h0);
    do_read(9'h110, 16, 0);
    chk1(busy_take, 1'h1);
    d = {8'h5A, 8'hC3};
    do_write(9'h1FE, d, 1'h0);
    d = {8'h3C, 8'h96};
    do_write(9'h000, d, 1'h0);
    // Slow reader fills the two-entry buffer across the array wrap
    do_read(9'h1FE, 4, 300);
    wp <= 1'h1;
    d = {8'h77};
    do_write(9'h1FE, d, 1'h1);
    d = {8'h44};
    do_write(9'h0F5, d, 1'h0);
    do_read(9'h1FE, 2, 0);
    do_read(9'h0F5, 1, 0);
    // A foreign chip select is never answered; only a reset frees the host
    cs <= 2'h1;
    run_cmd(1'h1, 9'h1FE, 5'h01, d, 0, 1'b1);
    chk1(fin, 1'h0);
    chk1(ack_seen, 1'h0);
    do_reset;
    cs <= 2'h2;
    do_read(9'h1FE, 1, 0);
    complete_run;
  end
endmodule : tb
`default_nettype wire
